/* File: hdl/dual_dac_channel_config_defs.vh */
// Purpose: constants for the dual channel converter configuration block
// Assumes: 50 MHz clock, synchronous active-high reset
// Notes:   span and reference encodings follow the register field codes
`ifndef DUAL_DAC_CHANNEL_CONFIG_DEFS_VH
`define DUAL_DAC_CHANNEL_CONFIG_DEFS_VH

// output span select codes (3-bit field)
`define SPAN_W            3
`define SPAN_0_2V5        3'h0
`define SPAN_0_5V         3'h1
`define SPAN_0_10V        3'h2
`define SPAN_M5_P5V       3'h3
`define SPAN_M2V5_P7V5    3'h4
`define SPAN_RESET        3'h0

// reference selection codes (2-bit field)
`define REF_W             2
`define REF_INT_FLOAT     2'h0
`define REF_INT_DRIVE     2'h1
`define REF_RESET         2'h0

// code word widths and layouts
`define CODE_W            16
`define WIDE_W            24
`define NARROW_PAD        4
`define NARROW_PAD_ZERO   4'h0
`define CODE_RESET        16'h0000
`define WIDE_RESET        24'h000000
`define WIDE_PAD          8'h00
`define CH_FLAGS_RESET    2'h0
`define AMP_RESET         2'h3
`define SPAN_ONEHOT_RESET 5'h01

// channel count and one-hot span decode width
`define NUM_CH            2
`define SPAN_ONEHOT_W     5

`endif

/* File: hdl/span_decoder.v */
// Purpose: decode the shared output span select field into a one-hot word
// Assumes: pure combinational helper, instantiated by the top block
// Notes:   reserved codes report invalid so the caller can hold the old span
`timescale 1ns/1ns
`include "dual_dac_channel_config_defs.vh"

module span_decoder
(
  // span code in
  input  wire [`SPAN_W-1:0]        i_code,
  // decode result
  output reg  [`SPAN_ONEHOT_W-1:0] o_onehot,
  output reg                       o_valid
);

  // one bit per defined span, all zero for reserved codes
  always @*
  begin
    o_onehot = 5'h00;
    o_valid  = 1'b1;
    case (i_code)
      `SPAN_0_2V5:     o_onehot = 5'h01;
      `SPAN_0_5V:      o_onehot = 5'h02;
      `SPAN_0_10V:     o_onehot = 5'h04;
      `SPAN_M5_P5V:    o_onehot = 5'h08;
      `SPAN_M2V5_P7V5: o_onehot = 5'h10;
      default:         o_valid  = 1'b0;
    endcase
  end

endmodule

/* File: hdl/dual_dac_channel_config.v */
// Purpose: configuration and code-loading logic of a dual channel converter
// Assumes: host writes arrive as one-cycle strobes synchronous to i_clock
// Notes:   the analog path sees o_ch*_code as the loaded straight-binary code
//
// How it works
// - fast mode loads 16-bit codes, two-byte registers
// - precision mode loads 24-bit codes, three-byte registers
// - 12-bit variant: fast only, wide writes ignored
// - span field decodes five defined output spans
// - code is unsigned binary, zero-scale at zero
// - 12-bit variant code equals code times sixteen
// - amplifiers on at reset; shutdown bit disables
// - internal reference enabled at reset
// - reference pin not driven after reset
// - reference field: float, drive, or external
// - external reference leaves pin undriven input
`timescale 1ns/1ns
`include "dual_dac_channel_config_defs.vh"

module dual_dac_channel_config
#(
  // 1 for the 12-bit variant, 0 for the 16-bit variant
  parameter NARROW_VARIANT = 0
)
(
  // clock and reset
  input  wire                     i_clock,
  input  wire                     i_srst,
  // two-byte code register writes, one strobe per channel
  input  wire [`NUM_CH-1:0]       i_two_byte_code_regs_we,
  input  wire [`CODE_W-1:0]       i_two_byte_code_regs_data,
  // three-byte code register writes, one strobe per channel
  input  wire [`NUM_CH-1:0]       i_three_byte_code_regs_we,
  input  wire [`WIDE_W-1:0]       i_three_byte_code_regs_data,
  // shared output span select write
  input  wire                     i_output_span_select_we,
  input  wire [`SPAN_W-1:0]       i_output_span_select,
  // power down settings write
  input  wire                     i_power_down_settings_we,
  input  wire [`NUM_CH-1:0]       i_channel_amp_shutdown,
  // reference selection write
  input  wire                     i_ref_select_we,
  input  wire [`REF_W-1:0]        i_ref_select,
  // per channel codes toward the converter cores
  output reg  [`CODE_W-1:0]       o_ch0_code,
  output reg  [`CODE_W-1:0]       o_ch1_code,
  output reg  [`WIDE_W-1:0]       o_ch0_wide_code,
  output reg  [`WIDE_W-1:0]       o_ch1_wide_code,
  output reg  [`NUM_CH-1:0]       o_precision_mode,
  output reg  [`NUM_CH-1:0]       o_code_update,
  // span state
  output reg  [`SPAN_W-1:0]       o_output_span_select,
  output reg  [`SPAN_ONEHOT_W-1:0] o_span_onehot,
  output reg                      o_span_rejected,
  // amplifier enables, one per channel output pin
  output reg  [`NUM_CH-1:0]       o_amp_enable,
  // reference control
  output reg                      o_int_ref_enable,
  output reg                      o_ext_ref_select,
  output reg  [`REF_W-1:0]        o_ref_select,
  output reg                      o_ref_pin_oe,
  // wide registers reachable only on the 16-bit variant
  output reg                      o_wide_regs_present
);

  // wide writes only exist on the full-resolution part
  localparam WIDE_OK = (NARROW_VARIANT == 0) ? 1'b1 : 1'b0;

  // decoded span of the incoming write
  wire [`SPAN_ONEHOT_W-1:0] new_onehot;
  wire                      new_valid;

  // forces the low nibble clear for the narrow part
  function [`CODE_W-1:0] narrow_align;
    input [`CODE_W-1:0] raw;
    begin
      if (NARROW_VARIANT != 0)
        narrow_align = {raw[`CODE_W-1:`NARROW_PAD], `NARROW_PAD_ZERO};
      else
        narrow_align = raw;
    end
  endfunction

  // gated wide strobes, dead on the narrow part
  wire [`NUM_CH-1:0] wide_we;
  assign wide_we = i_three_byte_code_regs_we & {`NUM_CH{WIDE_OK}};

  // next-value code words per channel
  reg [`CODE_W-1:0] next_code [0:`NUM_CH-1];

  span_decoder u_span_decoder
  (
    .i_code   (i_output_span_select),
    .o_onehot (new_onehot),
    .o_valid  (new_valid)
  );

  // code is passed unsigned; the low nibble is the only alteration
  genvar g;
  generate
    for (g = 0; g < `NUM_CH; g = g + 1)
    begin : g_next
      always @*
      begin
        next_code[g] = narrow_align(i_two_byte_code_regs_data);
      end
    end
  endgenerate

  // channel code registers and the mode each last write chose
  always @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_ch0_code       <= `CODE_RESET;
      o_ch1_code       <= `CODE_RESET;
      o_ch0_wide_code  <= `WIDE_RESET;
      o_ch1_wide_code  <= `WIDE_RESET;
      o_precision_mode <= `CH_FLAGS_RESET;
      o_code_update    <= `CH_FLAGS_RESET;
    end
    else
    begin
      o_code_update <= i_two_byte_code_regs_we | wide_we;
      // channel 0: wide write wins if both land together
      if (wide_we[0])
      begin
        o_ch0_wide_code     <= i_three_byte_code_regs_data;
        o_ch0_code          <= i_three_byte_code_regs_data[`WIDE_W-1:`WIDE_W-`CODE_W];
        o_precision_mode[0] <= 1'b1;
      end
      else if (i_two_byte_code_regs_we[0])
      begin
        o_ch0_code          <= next_code[0];
        o_ch0_wide_code     <= {next_code[0], `WIDE_PAD};
        o_precision_mode[0] <= 1'b0;
      end
      // channel 1 mirrors channel 0
      if (wide_we[1])
      begin
        o_ch1_wide_code     <= i_three_byte_code_regs_data;
        o_ch1_code          <= i_three_byte_code_regs_data[`WIDE_W-1:`WIDE_W-`CODE_W];
        o_precision_mode[1] <= 1'b1;
      end
      else if (i_two_byte_code_regs_we[1])
      begin
        o_ch1_code          <= next_code[1];
        o_ch1_wide_code     <= {next_code[1], `WIDE_PAD};
        o_precision_mode[1] <= 1'b0;
      end
    end
  end

  // span register; reserved codes leave the last good span in place
  always @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_output_span_select <= `SPAN_RESET;
      o_span_onehot        <= `SPAN_ONEHOT_RESET;
      o_span_rejected      <= 1'b0;
    end
    else
    begin
      o_span_rejected <= i_output_span_select_we & ~new_valid;
      if (i_output_span_select_we && new_valid)
      begin
        o_output_span_select <= i_output_span_select;
        o_span_onehot        <= new_onehot;
      end
    end
  end

  // amplifier enables: on after reset, shutdown bit turns one off
  always @(posedge i_clock)
  begin
    if (i_srst)
      o_amp_enable <= `AMP_RESET;
    else if (i_power_down_settings_we)
      o_amp_enable <= ~i_channel_amp_shutdown;
  end

  // reference control; pin stays quiet until software asks to drive it
  always @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_ref_select     <= `REF_RESET;
      o_int_ref_enable <= 1'b1;
      o_ext_ref_select <= 1'b0;
      o_ref_pin_oe     <= 1'b0;
    end
    else if (i_ref_select_we)
    begin
      o_ref_select <= i_ref_select;
      case (i_ref_select)
        `REF_INT_FLOAT:
        begin
          o_int_ref_enable <= 1'b1;
          o_ext_ref_select <= 1'b0;
          o_ref_pin_oe     <= 1'b0;
        end
        `REF_INT_DRIVE:
        begin
          o_int_ref_enable <= 1'b1;
          o_ext_ref_select <= 1'b0;
          o_ref_pin_oe     <= 1'b1;
        end
        default:
        begin
          // both external codes: pin becomes an input
          o_int_ref_enable <= 1'b0;
          o_ext_ref_select <= 1'b1;
          o_ref_pin_oe     <= 1'b0;
        end
      endcase
    end
  end

  // constant flag, registered so the output comes from a flip-flop
  always @(posedge i_clock)
  begin
    if (i_srst)
      o_wide_regs_present <= 1'b0;
    else
      o_wide_regs_present <= WIDE_OK;
  end

endmodule

/* File: bench/host_model.sv */
// Purpose: host that writes code and setting registers of the block
// Assumes: one write per call, strobe high for one rising edge
// Notes:   data lines show the inverse value once released
`timescale 1ns/1ns
module host_model
(
  // clock in
  input  wire        i_clock,
  // write strobes and shared data toward the block
  output reg  [1:0]  o_we2,
  output reg  [1:0]  o_we3,
  output reg         o_span_we,
  output reg         o_pd_we,
  output reg         o_ref_we,
  output reg  [23:0] o_data
);
  initial
  begin
    {o_we2, o_we3, o_span_we, o_pd_we, o_ref_we} = 7'h00;
    o_data = 24'h000000;
  end
  // kind 0 two-byte, 1 three-byte, 2 span, 3 shutdown, 4 reference
  task wr(input [2:0] kind, input [1:0] sel, input [23:0] d);
    begin
      @(negedge i_clock);
      o_data = d;
      o_we2 = (kind == 3'h0) ? sel : 2'h0;
      o_we3 = (kind == 3'h1) ? sel : 2'h0;
      o_span_we = (kind == 3'h2);
      o_pd_we = (kind == 3'h3);
      o_ref_we = (kind == 3'h4);
      @(negedge i_clock);
      {o_we2, o_we3, o_span_we, o_pd_we, o_ref_we} = 7'h00;
      // released data is scrambled so stale values never pass
      o_data = ~d;
    end
  endtask
endmodule

/* File: bench/dual_dac_channel_config_asserts.sv */
// Purpose: port level checks of the configuration block
// Assumes: single clock, synchronous active-high reset
// Notes:   wide-wins on a shared channel write is not checked here
`timescale 1ns/1ns
`include "dual_dac_channel_config_defs.vh"
module dual_dac_channel_config_chk
(
  input wire                 i_clock,
  input wire                 i_srst,
  input wire [`NUM_CH-1:0]   i_two_byte_code_regs_we,
  input wire [`CODE_W-1:0]   i_two_byte_code_regs_data,
  input wire [`NUM_CH-1:0]   i_three_byte_code_regs_we,
  input wire                 i_output_span_select_we,
  input wire [`SPAN_W-1:0]   i_output_span_select,
  input wire                 i_power_down_settings_we,
  input wire [`NUM_CH-1:0]   i_channel_amp_shutdown,
  input wire                 i_ref_select_we,
  input wire [`REF_W-1:0]    i_ref_select,
  input wire [`CODE_W-1:0]   o_ch0_code,
  input wire [`NUM_CH-1:0]   o_code_update,
  input wire [`SPAN_W-1:0]   o_output_span_select,
  input wire [`NUM_CH-1:0]   o_amp_enable,
  input wire                 o_int_ref_enable,
  input wire [`REF_W-1:0]    o_ref_select,
  input wire                 o_ref_pin_oe
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  code_load_a: assert property (i_two_byte_code_regs_we[0] && !i_three_byte_code_regs_we[0]
    |=> o_ch0_code == $past(i_two_byte_code_regs_data) && o_code_update[0]) else $error("code load");
  no_update_a: assert property (!$past(i_two_byte_code_regs_we[0])
    && !$past(i_three_byte_code_regs_we[0]) |-> !o_code_update[0]) else $error("stray update");
  span_take_a: assert property (i_output_span_select_we && i_output_span_select <= 3'h4
    |=> o_output_span_select == $past(i_output_span_select)) else $error("span take");
  span_keep_a: assert property (i_output_span_select_we && i_output_span_select > 3'h4
    |=> $stable(o_output_span_select)) else $error("span kept");
  amp_ctl_a: assert property (i_power_down_settings_we
    |=> o_amp_enable == ~$past(i_channel_amp_shutdown)) else $error("amp control");
  ref_drive_a: assert property (o_ref_pin_oe |-> o_ref_select == 2'h1)
    else $error("pin driven");
  ref_ext_a: assert property (i_ref_select_we && i_ref_select[1] |=> !o_ref_pin_oe[*3])
    else $error("ext ref driven");
  reset_vals_a: assert property ($past(i_srst) |-> o_amp_enable == 2'h3
    && o_int_ref_enable && !o_ref_pin_oe) else $error("reset values");
endmodule
bind dual_dac_channel_config dual_dac_channel_config_chk chk_u (.*);

/* File: bench/testbench.sv */
// Purpose: self-checking bench of the configuration block, both variants
// Assumes: host model writes at falling edges
// Notes:   span codes run from a row table, the rest is hand written
`timescale 1ns/1ns
module testbench;
  reg         i_clock = 1'b0;
  reg         i_srst = 1'b1;
  integer     n_errors = 0;
  integer     checks_done = 0;
  integer     k;
  wire [1:0]  we2, we3, amp, upd, prec;
  wire        span_we, pd_we, ref_we, int_ref, ext_ref, oe;
  wire [23:0] data, wide0;
  wire [15:0] c0, c1;
  wire [2:0]  span;
  wire [15:0] c0n;
  wire [1:0]  precn, updn, refsel;
  wire        present, presentn, rej;
  wire [4:0]  onehot;
  wire [23:0] wide1;
  reg  [2:0]  rows_in [0:7];
  reg  [2:0]  rows_exp [0:7];
  initial forever #10 i_clock = ~i_clock;
  host_model host_u (.i_clock(i_clock), .o_we2(we2), .o_we3(we3), .o_span_we(span_we),
    .o_pd_we(pd_we), .o_ref_we(ref_we), .o_data(data));
  dual_dac_channel_config dut_u (.i_clock(i_clock), .i_srst(i_srst),
    .i_two_byte_code_regs_we(we2), .i_two_byte_code_regs_data(data[15:0]),
    .i_three_byte_code_regs_we(we3), .i_three_byte_code_regs_data(data),
    .i_output_span_select_we(span_we), .i_output_span_select(data[2:0]),
    .i_power_down_settings_we(pd_we), .i_channel_amp_shutdown(data[1:0]),
    .i_ref_select_we(ref_we), .i_ref_select(data[1:0]), .o_ch0_code(c0), .o_ch1_code(c1),
    .o_ch0_wide_code(wide0), .o_ch1_wide_code(wide1), .o_precision_mode(prec),
    .o_code_update(upd), .o_output_span_select(span), .o_span_onehot(onehot),
    .o_span_rejected(rej), .o_amp_enable(amp), .o_int_ref_enable(int_ref),
    .o_ext_ref_select(ext_ref), .o_ref_select(refsel), .o_ref_pin_oe(oe),
    .o_wide_regs_present(present));
  // 12-bit variant beside it; its host side keeps the low nibble clear
  dual_dac_channel_config #(.NARROW_VARIANT(1)) dut_narrow_u (.i_clock(i_clock),
    .i_srst(i_srst), .i_two_byte_code_regs_we(we2),
    .i_two_byte_code_regs_data({data[15:4], 4'h0}),
    .i_three_byte_code_regs_we(we3), .i_three_byte_code_regs_data(data),
    .i_output_span_select_we(span_we), .i_output_span_select(data[2:0]),
    .i_power_down_settings_we(pd_we), .i_channel_amp_shutdown(data[1:0]),
    .i_ref_select_we(ref_we), .i_ref_select(data[1:0]), .o_ch0_code(c0n), .o_ch1_code(),
    .o_ch0_wide_code(), .o_ch1_wide_code(), .o_precision_mode(precn),
    .o_code_update(updn), .o_output_span_select(), .o_span_onehot(),
    .o_span_rejected(), .o_amp_enable(), .o_int_ref_enable(),
    .o_ext_ref_select(), .o_ref_select(), .o_ref_pin_oe(), .o_wide_regs_present(presentn));
  // compare one value, count it, report a mismatch
  task chk(input [47:0] seen, input [47:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // watchdog: the whole run needs well under 200 cycles
  initial
  begin
    #100000;
    n_errors = n_errors + 1;
    final_report;
  end
  initial
  begin
    {rows_in[0], rows_in[1], rows_in[2], rows_in[3]} = {3'h1, 3'h5, 3'h2, 3'h7};
    {rows_in[4], rows_in[5], rows_in[6], rows_in[7]} = {3'h3, 3'h6, 3'h4, 3'h0};
    {rows_exp[0], rows_exp[1], rows_exp[2], rows_exp[3]} = {3'h1, 3'h1, 3'h2, 3'h2};
    {rows_exp[4], rows_exp[5], rows_exp[6], rows_exp[7]} = {3'h3, 3'h3, 3'h4, 3'h0};
    repeat (20) @(negedge i_clock);
    i_srst = 1'b0;
    @(negedge i_clock);
    chk(amp, 2'h3);
    chk(int_ref, 1'b1);
    chk(oe, 1'b0);
    chk({span, c0}, 19'h0);
    chk({present, presentn}, 2'h2);
    $display("reset test done");
    // reserved codes must leave the last valid span in place
    for (k = 0; k < 8; k = k + 1)
    begin
      host_u.wr(3'h2, 2'h0, {21'h0, rows_in[k]});
      chk(span, rows_exp[k]);
      chk({rej, onehot}, {rows_in[k] > 3'h4, 5'h01 << rows_exp[k]});
    end
    $display("span test done");
    host_u.wr(3'h0, 2'h1, 24'h00FFFF);
    chk({upd, c0}, {2'h1, 16'hFFFF});
    chk(c0n, 16'hFFF0);
    host_u.wr(3'h0, 2'h2, 24'h000001);
    chk({upd, c1, c0}, {2'h2, 16'h0001, 16'hFFFF});
    chk(wide1, 24'h000100);
    host_u.wr(3'h1, 2'h1, 24'hABCDEF);
    chk({prec, wide0, c0}, {2'h1, 24'hABCDEF, 16'hABCD});
    chk({precn, updn, c0n}, {2'h0, 2'h0, 16'hFFF0});
    $display("code test done");
    for (k = 0; k < 4; k = k + 1)
    begin
      host_u.wr(3'h4, 2'h0, k[23:0]);
      chk({oe, int_ref, ext_ref, refsel}, {k == 1, k < 2, k > 1, k[1:0]});
    end
    host_u.wr(3'h3, 2'h0, 24'h000001);
    chk(amp, 2'h2);
    host_u.wr(3'h3, 2'h0, 24'h000000);
    chk(amp, 2'h3);
    $display("reference and shutdown test done");
    // mid-run reset from a changed state must restore the power-up settings
    host_u.wr(3'h3, 2'h0, 24'h000003);
    chk(amp, 2'h0);
    host_u.wr(3'h4, 2'h0, 24'h000001);
    i_srst = 1'b1;
    repeat (2) @(negedge i_clock);
    i_srst = 1'b0;
    @(negedge i_clock);
    chk({amp, int_ref, ext_ref, oe}, 5'h1C);
    chk({span, c0}, 19'h0);
    $display("mid-run reset test done");
    final_report;
  end
endmodule
